// File: core/bgcu_general_ctrl.sv
// Upper bits of the bridge general control register, with the effects they steer.
// Function
// - Retry a forwarded configuration request for the selected time before answering retry status.
// - Retry time field: 00 25 us, 01 1 ms, 10 25 ms default, 11 50 ms.
// - Bits 29:28 give the power-up value of the link active-state control bits.
// - That value maps straight: off, L0s, L1, or both L0s and L1.
// - Bit 27 set puts the transmit drivers in half amplitude without pre-emphasis.
// - Bit 26 selects the reported power management revision and no-soft-reset bit.
// - Bit 26 low reports revision 010b and 0; high reports 011b and 1.
// - Bit 24 always reads zero and ignores writes.
// - Bit 23 sets clock power management power-up value: 0 gives 00b, 1 gives 11b.
// - Fundamental, global and power-on reset all return the fields to defaults.
// - The register sits at configuration offset D4h.
`timescale 1ns/1ns
`include "bgcu_params.svh"

module bgcu_general_ctrl #(
	parameter int unsigned RETRY_T0_CYC = `BGCU_RETRY_T0_CYC,
	parameter int unsigned RETRY_T1_CYC = `BGCU_RETRY_T1_CYC,
	parameter int unsigned RETRY_T2_CYC = `BGCU_RETRY_T2_CYC,
	parameter int unsigned RETRY_T3_CYC = `BGCU_RETRY_T3_CYC
) (
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic FUND_RST_I,
	input wire logic GLOBAL_RESET_IN_I,
	input wire logic CFG_RD_I,
	input wire logic CFG_WR_I,
	input wire logic [`BGCU_ADDR_W-1:0] CFG_ADDR_I,
	input wire logic [3:0] CFG_BE_I,
	input wire logic [31:0] CFG_WDATA_I,
	input wire logic LOAD_I,
	input wire logic [31:0] LOAD_DATA_I,
	input wire logic LINK_CTRL_WR_I,
	input wire logic [1:0] LINK_ASPM_WDATA_I,
	input wire logic [1:0] LINK_CLK_PM_WDATA_I,
	input wire logic RETRY_START_I,
	input wire logic RETRY_DONE_I,
	output logic CFG_ACK_O,
	output logic [31:0] CFG_RDATA_O,
	output logic RETRY_BUSY_O,
	output logic CRS_ALLOWED_O,
	output logic TX_LOW_SWING_O,
	output logic [2:0] PM_REVISION_FIELD_O,
	output logic PM_NO_SOFT_RST_O,
	output bgcu_pkg::bgcu_aspm_t LINK_ASPM_CTRL_O,
	output logic [1:0] CLOCK_PM_ENABLE_FIELD_O
);

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks.

	localparam int unsigned RETRY_CYC [4] = '{RETRY_T0_CYC, RETRY_T1_CYC, RETRY_T2_CYC, RETRY_T3_CYC};

	// A retry of one cycle would allow retry status on the second cycle after start, earlier than the early-status check permits.
	for (genvar k = 0; k < 4; k++) begin : g_retry_check
		if (RETRY_CYC[k] < 2) begin : g_short
			$error("Each retry time must be at least two clock cycles.");
		end
		if (RETRY_CYC[k] >= (64'h1 << `BGCU_RETRY_CNT_W)) begin : g_long
			$error("Each retry time must fit the retry counter.");
		end
	end

	// The address compare ignores the two low bits, so the offset must be word aligned.
	if (`BGCU_GCR_OFFSET % 4 != 0) begin : g_bad_offset
		$error("The register offset must be word aligned.");
	end

	// The read word is packed by concatenation, so the field positions must stay in this order.
	if (`BGCU_RETRY_HI != 31 || `BGCU_RETRY_LO != `BGCU_ASPM_HI + 1 || `BGCU_ASPM_LO != `BGCU_LOW_SWING_BIT + 1 ||
		`BGCU_LOW_SWING_BIT != `BGCU_PM_REV_SEL_BIT + 1 || `BGCU_PM_REV_SEL_BIT != `BGCU_RSVD_RW_BIT + 1 ||
		`BGCU_RSVD_RW_BIT != `BGCU_RSVD_RO_BIT + 1 || `BGCU_RSVD_RO_BIT != `BGCU_CLK_PM_BIT + 1 ||
		`BGCU_CLK_PM_BIT != 23) begin : g_bad_layout
		$error("Field positions no longer match the packed read word.");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decoding used by several fields.

	function automatic logic [3:0] pm_report(input logic sel);
		pm_report = sel ? {1'b1, `BGCU_PM_REV_NEW} : {1'b0, `BGCU_PM_REV_OLD};
	endfunction : pm_report

	function automatic logic [1:0] clk_pm_default(input logic sel);
		clk_pm_default = sel ? `BGCU_CLK_PM_ON : `BGCU_CLK_PM_OFF;
	endfunction : clk_pm_default

	////////////////////////////////////////////////////////////////////////////////
	// Field storage and write path.

	logic [1:0] retry_sel_reg;
	logic [1:0] retry_sel_next;
	logic [1:0] aspm_def_reg;
	logic [1:0] aspm_def_next;
	logic low_swing_reg;
	logic low_swing_next;
	logic pm_rev_sel_reg;
	logic pm_rev_sel_next;
	logic rsvd_rw_reg;
	logic rsvd_rw_next;
	logic clk_pm_def_reg;
	logic clk_pm_def_next;

	wire sync_rst = FUND_RST_I | GLOBAL_RESET_IN_I;
	wire addr_hit = ({CFG_ADDR_I[`BGCU_ADDR_W-1:2], 2'b00} == `BGCU_GCR_OFFSET);
	wire rd_hit = CFG_RD_I & addr_hit;
	wire wr_hit = CFG_WR_I & addr_hit;
	// Lane 3 carries bits 31:25; of lane 2 only bit 23 lives here, the rest belongs elsewhere.
	wire wr_upper = wr_hit & CFG_BE_I[`BGCU_BE_UPPER];
	wire wr_bit23 = wr_hit & CFG_BE_I[`BGCU_BE_BIT23];

	// A reload carries the whole word, so it rewrites every field unless a reset comes in the same cycle.
	wire up_en = LOAD_I | wr_upper;
	wire b23_en = LOAD_I | wr_bit23;
	wire [31:0] up_data = LOAD_I ? LOAD_DATA_I : CFG_WDATA_I;

	assign retry_sel_next = sync_rst ? `BGCU_RETRY_RST :
		up_en ? up_data[`BGCU_RETRY_HI:`BGCU_RETRY_LO] : retry_sel_reg;
	assign aspm_def_next = sync_rst ? `BGCU_ASPM_RST :
		up_en ? up_data[`BGCU_ASPM_HI:`BGCU_ASPM_LO] : aspm_def_reg;
	assign low_swing_next = sync_rst ? `BGCU_LOW_SWING_RST :
		up_en ? up_data[`BGCU_LOW_SWING_BIT] : low_swing_reg;
	assign pm_rev_sel_next = sync_rst ? `BGCU_PM_REV_SEL_RST :
		up_en ? up_data[`BGCU_PM_REV_SEL_BIT] : pm_rev_sel_reg;
	// The reserved bit is stored as written; keeping it zero is the programmer's duty.
	assign rsvd_rw_next = sync_rst ? `BGCU_RSVD_RW_RST :
		up_en ? up_data[`BGCU_RSVD_RW_BIT] : rsvd_rw_reg;
	assign clk_pm_def_next = sync_rst ? `BGCU_CLK_PM_RST :
		b23_en ? up_data[`BGCU_CLK_PM_BIT] : clk_pm_def_reg;

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			retry_sel_reg <= `BGCU_RETRY_RST;
			aspm_def_reg <= `BGCU_ASPM_RST;
			low_swing_reg <= `BGCU_LOW_SWING_RST;
			pm_rev_sel_reg <= `BGCU_PM_REV_SEL_RST;
			rsvd_rw_reg <= `BGCU_RSVD_RW_RST;
			clk_pm_def_reg <= `BGCU_CLK_PM_RST;
		end else begin
			retry_sel_reg <= retry_sel_next;
			aspm_def_reg <= aspm_def_next;
			low_swing_reg <= low_swing_next;
			pm_rev_sel_reg <= pm_rev_sel_next;
			rsvd_rw_reg <= rsvd_rw_next;
			clk_pm_def_reg <= clk_pm_def_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path; bits 22:0 belong to other logic and read as zero here.

	// Bit 24 is a constant zero, so a write to it is lost by construction.
	wire [31:0] gcr_word = {retry_sel_reg, aspm_def_reg, low_swing_reg, pm_rev_sel_reg,
		rsvd_rw_reg, 1'b0, clk_pm_def_reg, 23'h000000};
	wire [31:0] rdata_next = rd_hit ? gcr_word : 32'h00000000;
	// Writes are acknowledged as well, so a master counts completions the same way for both.
	wire ack_next = rd_hit | wr_hit;

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			CFG_ACK_O <= 1'b0;
			CFG_RDATA_O <= 32'h00000000;
		end else begin
			CFG_ACK_O <= ack_next;
			CFG_RDATA_O <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Effects steered by the fields. Computed from next values so the outputs track the field
	// in the same edge that stores it, with no extra cycle of lag.

	wire [3:0] pm_next = pm_report(pm_rev_sel_next);
	wire [2:0] pm_rev_next = pm_next[2:0];
	wire pm_no_soft_next = pm_next[3];
	// Defaults win over a software write of link control in the same cycle, as a reset must.
	wire load_defaults = sync_rst | LOAD_I;
	wire [1:0] aspm_default = aspm_def_next;
	wire [1:0] clk_pm_fill = clk_pm_default(clk_pm_def_next);
	wire [1:0] aspm_ctl_next = load_defaults ? aspm_default :
		LINK_CTRL_WR_I ? LINK_ASPM_WDATA_I : LINK_ASPM_CTRL_O;
	wire [1:0] clk_pm_ctl_next = load_defaults ? clk_pm_fill :
		LINK_CTRL_WR_I ? LINK_CLK_PM_WDATA_I : CLOCK_PM_ENABLE_FIELD_O;

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			TX_LOW_SWING_O <= `BGCU_LOW_SWING_RST;
			PM_REVISION_FIELD_O <= `BGCU_PM_REV_NEW;
			PM_NO_SOFT_RST_O <= 1'b1;
			LINK_ASPM_CTRL_O <= bgcu_pkg::BGCU_ASPM_OFF;
			CLOCK_PM_ENABLE_FIELD_O <= `BGCU_CLK_PM_OFF;
		end else begin
			TX_LOW_SWING_O <= low_swing_next;
			PM_REVISION_FIELD_O <= pm_rev_next;
			PM_NO_SOFT_RST_O <= pm_no_soft_next;
			LINK_ASPM_CTRL_O <= bgcu_pkg::bgcu_aspm_t'(aspm_ctl_next);
			CLOCK_PM_ENABLE_FIELD_O <= clk_pm_ctl_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Secondary bus retry timing.

	bgcu_retry_timer #(
		.CNT_W(`BGCU_RETRY_CNT_W),
		.T0_CYC(RETRY_T0_CYC),
		.T1_CYC(RETRY_T1_CYC),
		.T2_CYC(RETRY_T2_CYC),
		.T3_CYC(RETRY_T3_CYC)
	) u_retry_timer (
		.clk_i(CLK_I),
		.nrst_i(NRST_I),
		.sync_rst_i(sync_rst),
		.start_i(RETRY_START_I),
		.done_i(RETRY_DONE_I),
		.sel_i(retry_sel_reg),
		.busy_o(RETRY_BUSY_O),
		.expired_o(CRS_ALLOWED_O)
	);

endmodule : bgcu_general_ctrl

// File: core/bgcu_params.svh
// Offsets, field positions, reset values and timing figures of the general bridge control upper bits.
`ifndef BGCU_PARAMS_SVH
`define BGCU_PARAMS_SVH

`define BGCU_ADDR_W 12
`define BGCU_GCR_OFFSET 12'h0D4

`define BGCU_RETRY_HI 31
`define BGCU_RETRY_LO 30
`define BGCU_ASPM_HI 29
`define BGCU_ASPM_LO 28
`define BGCU_LOW_SWING_BIT 27
`define BGCU_PM_REV_SEL_BIT 26
`define BGCU_RSVD_RW_BIT 25
`define BGCU_RSVD_RO_BIT 24
`define BGCU_CLK_PM_BIT 23
`define BGCU_BE_UPPER 3
`define BGCU_BE_BIT23 2

`define BGCU_RETRY_RST 2'h2
`define BGCU_ASPM_RST 2'h0
`define BGCU_LOW_SWING_RST 1'h0
`define BGCU_PM_REV_SEL_RST 1'h1
`define BGCU_RSVD_RW_RST 1'h0
`define BGCU_CLK_PM_RST 1'h0

`define BGCU_PM_REV_OLD 3'h2
`define BGCU_PM_REV_NEW 3'h3
`define BGCU_CLK_PM_OFF 2'h0
`define BGCU_CLK_PM_ON 2'h3

`define BGCU_CLK_MHZ 100
`define BGCU_RETRY_T0_US 25
`define BGCU_RETRY_T1_MS 1
`define BGCU_RETRY_T2_MS 25
`define BGCU_RETRY_T3_MS 50
`define BGCU_RETRY_T0_CYC (`BGCU_RETRY_T0_US * `BGCU_CLK_MHZ)
`define BGCU_RETRY_T1_CYC (`BGCU_RETRY_T1_MS * 1000 * `BGCU_CLK_MHZ)
`define BGCU_RETRY_T2_CYC (`BGCU_RETRY_T2_MS * 1000 * `BGCU_CLK_MHZ)
`define BGCU_RETRY_T3_CYC (`BGCU_RETRY_T3_MS * 1000 * `BGCU_CLK_MHZ)
`define BGCU_RETRY_CNT_W 23

`endif

// File: core/bgcu_pkg.sv
// Types shared by the general bridge control upper bits and its retry timer.
package bgcu_pkg;

	typedef logic [1:0] bgcu_retry_sel_t;

	typedef enum logic [1:0] {
		BGCU_ASPM_OFF,
		BGCU_ASPM_L0S,
		BGCU_ASPM_L1,
		BGCU_ASPM_BOTH
	} bgcu_aspm_t;

	typedef enum logic [1:0] {
		BGCU_RT_IDLE,
		BGCU_RT_RETRY,
		BGCU_RT_EXPIRED
	} bgcu_rt_state_t;

endpackage : bgcu_pkg

// File: core/bgcu_retry_timer.sv
// Times how long a forwarded configuration request has been retried on the secondary bus.
`timescale 1ns/1ns
`include "bgcu_params.svh"

module bgcu_retry_timer #(
	parameter int unsigned CNT_W = `BGCU_RETRY_CNT_W,
	parameter int unsigned T0_CYC = `BGCU_RETRY_T0_CYC,
	parameter int unsigned T1_CYC = `BGCU_RETRY_T1_CYC,
	parameter int unsigned T2_CYC = `BGCU_RETRY_T2_CYC,
	parameter int unsigned T3_CYC = `BGCU_RETRY_T3_CYC
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic sync_rst_i,
	input wire logic start_i,
	input wire logic done_i,
	input wire bgcu_pkg::bgcu_retry_sel_t sel_i,
	output logic busy_o,
	output logic expired_o
);

	////////////////////////////////////////////////////////////////////////////////
	if (T0_CYC < 1 || T1_CYC < 1 || T2_CYC < 1 || T3_CYC < 1 ||
		T0_CYC >= (64'h1 << CNT_W) || T1_CYC >= (64'h1 << CNT_W) ||
		T2_CYC >= (64'h1 << CNT_W) || T3_CYC >= (64'h1 << CNT_W)) begin : g_bad_limits
		$error("Retry limits must be at least one cycle and fit the counter.");
	end

	bgcu_pkg::bgcu_rt_state_t state_reg;
	bgcu_pkg::bgcu_rt_state_t state_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic [CNT_W-1:0] limit_m1;

	// The selection is taken at the start, so a field rewrite never bends a retry already running.
	assign limit_m1 = (sel_i == 2'h0) ? CNT_W'(T0_CYC - 1) :
		(sel_i == 2'h1) ? CNT_W'(T1_CYC - 1) :
		(sel_i == 2'h2) ? CNT_W'(T2_CYC - 1) : CNT_W'(T3_CYC - 1);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		if (done_i) begin
			state_next = bgcu_pkg::BGCU_RT_IDLE;
			cnt_next = '0;
		end else if (start_i) begin
			state_next = bgcu_pkg::BGCU_RT_RETRY;
			cnt_next = limit_m1;
		end else begin
			unique case (state_reg)
				bgcu_pkg::BGCU_RT_IDLE: begin
					cnt_next = '0;
				end
				bgcu_pkg::BGCU_RT_RETRY: begin
					if (cnt_reg == '0) begin
						state_next = bgcu_pkg::BGCU_RT_EXPIRED;
					end else begin
						cnt_next = cnt_reg - CNT_W'(1);
					end
				end
				bgcu_pkg::BGCU_RT_EXPIRED: begin
					cnt_next = '0;
				end
				default: begin
					state_next = bgcu_pkg::BGCU_RT_IDLE;
					cnt_next = '0;
				end
			endcase
		end
		if (sync_rst_i) begin
			state_next = bgcu_pkg::BGCU_RT_IDLE;
			cnt_next = '0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= bgcu_pkg::BGCU_RT_IDLE;
			cnt_reg <= '0;
			busy_o <= 1'b0;
			expired_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			busy_o <= (state_next == bgcu_pkg::BGCU_RT_RETRY);
			expired_o <= (state_next == bgcu_pkg::BGCU_RT_EXPIRED);
		end
	end

endmodule : bgcu_retry_timer

// File: testbench/bgcu_general_ctrl_properties.sv
// Concurrent checks on the ports of the general bridge control upper bits.
`timescale 1ns/1ns
module bgcu_gc_props (
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire logic FUND_RST_I,
	input wire logic GLOBAL_RESET_IN_I,
	input wire logic CFG_RD_I,
	input wire logic CFG_WR_I,
	input wire logic [11:0] CFG_ADDR_I,
	input wire logic [3:0] CFG_BE_I,
	input wire logic [31:0] CFG_WDATA_I,
	input wire logic LOAD_I,
	input wire logic [31:0] LOAD_DATA_I,
	input wire logic RETRY_START_I,
	input wire logic RETRY_DONE_I,
	input wire logic CFG_ACK_O,
	input wire logic [31:0] CFG_RDATA_O,
	input wire logic RETRY_BUSY_O,
	input wire logic CRS_ALLOWED_O,
	input wire logic TX_LOW_SWING_O,
	input wire logic [2:0] PM_REVISION_FIELD_O,
	input wire logic PM_NO_SOFT_RST_O,
	input wire bgcu_pkg::bgcu_aspm_t LINK_ASPM_CTRL_O,
	input wire logic [1:0] CLOCK_PM_ENABLE_FIELD_O
);
	wire hit = (CFG_RD_I || CFG_WR_I) && CFG_ADDR_I[11:2] == 10'h035;
	// Resets and reloads win over a write, so they are kept out of the write checks.
	wire quiet = !FUND_RST_I && !GLOBAL_RESET_IN_I && !LOAD_I;
	wire srst = FUND_RST_I || GLOBAL_RESET_IN_I;
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);
	////////////////////////////////////////////////////////////////////////////////
	property p_ack; hit |=> CFG_ACK_O; endproperty
	a_ack: assert property (p_ack) else $error("hit access not acknowledged");
	property p_no_ack; !hit |=> !CFG_ACK_O; endproperty
	a_no_ack: assert property (p_no_ack) else $error("ack without hit access");
	property p_rsvd; CFG_ACK_O |-> CFG_RDATA_O[24] == 1'b0 && CFG_RDATA_O[22:0] == 23'h000000; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
	property p_rev; PM_REVISION_FIELD_O == (PM_NO_SOFT_RST_O ? 3'h3 : 3'h2); endproperty
	a_rev: assert property (p_rev) else $error("revision and no-soft-reset disagree");
	property p_swing;
		CFG_WR_I && hit && CFG_BE_I[3] && quiet |=>
			TX_LOW_SWING_O == $past(CFG_WDATA_I[27]) && PM_NO_SOFT_RST_O == $past(CFG_WDATA_I[26]);
	endproperty
	a_swing: assert property (p_swing) else $error("written upper lane not applied");
	property p_srst;
		srst |=> PM_NO_SOFT_RST_O && !TX_LOW_SWING_O && LINK_ASPM_CTRL_O == 2'h0 && CLOCK_PM_ENABLE_FIELD_O == 2'h0;
	endproperty
	a_srst: assert property (p_srst) else $error("sync reset left non-default state");
	property p_load;
		LOAD_I && !srst |=> LINK_ASPM_CTRL_O == $past(LOAD_DATA_I[29:28])
			&& CLOCK_PM_ENABLE_FIELD_O == {2{$past(LOAD_DATA_I[23])}};
	endproperty
	a_load: assert property (p_load) else $error("reload did not set link control");
	property p_crs; $rose(CRS_ALLOWED_O) |-> $past(RETRY_BUSY_O) && !RETRY_BUSY_O; endproperty
	a_crs: assert property (p_crs) else $error("retry status allowed without timing");
	property p_early; RETRY_START_I && !RETRY_DONE_I |=> !CRS_ALLOWED_O [*2]; endproperty
	a_early: assert property (p_early) else $error("retry status allowed too early");
	property p_done; RETRY_DONE_I |=> !CRS_ALLOWED_O && !RETRY_BUSY_O; endproperty
	a_done: assert property (p_done) else $error("timer not idle after done");
	c_read: cover property (CFG_RD_I && hit ##1 CFG_ACK_O);
	c_crs: cover property ($rose(CRS_ALLOWED_O));
	c_load: cover property (LOAD_I);
endmodule : bgcu_gc_props

bind bgcu_general_ctrl bgcu_gc_props u_props (.*);

// File: testbench/bgcu_general_ctrl_bench.sv
// Self-checking bench for the general bridge control upper bits.
`timescale 1ns/1ns
`include "bgcu_params.svh"
module bgcu_general_ctrl_bench;
	// Short retry counts keep the run brief; every expectation uses these values.
	localparam int unsigned N0 = 2, N1 = 3, N2 = 5, N3 = 7;
	localparam logic [11:0] RA = `BGCU_GCR_OFFSET;
	int unsigned nt [4] = '{N0, N1, N2, N3};
	logic clk = 1'b0, nrst = 1'b0, frst = 1'b0, global_reset_in = 1'b0, rd = 1'b0, wr = 1'b0;
	logic load = 1'b0, lwr = 1'b0, start = 1'b0, done = 1'b0;
	logic [11:0] addr = 12'h0D4;
	logic [3:0] be = 4'hF;
	logic [31:0] wdata = 32'h0, ldata = 32'h0, rdata;
	logic [1:0] laspm = 2'h0, lcpm = 2'h0, cpm;
	logic ack, busy, crs, swing, nosoft;
	logic [2:0] rev;
	bgcu_pkg::bgcu_aspm_t aspm;
	wire [8:0] outs = {rev, nosoft, swing, aspm, cpm};
	int bad_count = 0, num_checks = 0;
	always #5 clk = ~clk;
	bgcu_general_ctrl #(.RETRY_T0_CYC(N0), .RETRY_T1_CYC(N1), .RETRY_T2_CYC(N2), .RETRY_T3_CYC(N3)) dut (
		.CLK_I(clk), .NRST_I(nrst), .FUND_RST_I(frst), .GLOBAL_RESET_IN_I(global_reset_in), .CFG_RD_I(rd),
		.CFG_WR_I(wr), .CFG_ADDR_I(addr), .CFG_BE_I(be), .CFG_WDATA_I(wdata), .LOAD_I(load),
		.LOAD_DATA_I(ldata), .LINK_CTRL_WR_I(lwr), .LINK_ASPM_WDATA_I(laspm), .LINK_CLK_PM_WDATA_I(lcpm),
		.RETRY_START_I(start), .RETRY_DONE_I(done), .CFG_ACK_O(ack), .CFG_RDATA_O(rdata),
		.RETRY_BUSY_O(busy), .CRS_ALLOWED_O(crs), .TX_LOW_SWING_O(swing), .PM_REVISION_FIELD_O(rev),
		.PM_NO_SOFT_RST_O(nosoft), .LINK_ASPM_CTRL_O(aspm), .CLOCK_PM_ENABLE_FIELD_O(cpm));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task acc(input logic w, input logic [11:0] a, input logic [3:0] b, input logic [31:0] d,
			input logic ea, input logic [31:0] ed);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		be <= b;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
		chk(ack, ea);
		chk(rdata, ed);
	endtask : acc
	task pulse_sync(input logic f);
		@(posedge clk);
		frst <= f;
		global_reset_in <= !f;
		@(posedge clk);
		frst <= 1'b0;
		global_reset_in <= 1'b0;
		#1;
	endtask : pulse_sync
	////////////////////////////////////////////////////////////////////////////////
	task t_fields;
		acc(1'b0, RA, 4'hF, 32'h0, 1'b1, 32'h84000000);
		chk(outs, 9'h0E0);
		acc(1'b1, RA, 4'hF, 32'hFD800000, 1'b1, 32'h0);
		acc(1'b0, RA, 4'hF, 32'h0, 1'b1, 32'hFC800000);
		chk(outs, 9'h0F0);
		acc(1'b1, RA, 4'h8, 32'h0, 1'b1, 32'h0);
		acc(1'b0, RA, 4'hF, 32'h0, 1'b1, 32'h00800000);
		chk(outs, 9'h080);
		acc(1'b1, RA, 4'h4, 32'h0, 1'b1, 32'h0);
		acc(1'b1, 12'h0D0, 4'hF, 32'hFFFFFFFF, 1'b0, 32'h0);
		acc(1'b0, 12'h0D8, 4'hF, 32'h0, 1'b0, 32'h0);
		acc(1'b0, RA, 4'hF, 32'h0, 1'b1, 32'h0);
		$display("fields test done");
	endtask : t_fields
	task t_load;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			load <= 1'b1;
			ldata <= {2'h2, i[1:0], 2'h1, 2'h0, i[2], 23'h0};
			@(posedge clk);
			load <= 1'b0;
			#1;
			chk({aspm, cpm}, {i[1:0], {2{i[2]}}});
		end
		@(posedge clk);
		lwr <= 1'b1;
		laspm <= 2'h1;
		lcpm <= 2'h2;
		@(posedge clk);
		lwr <= 1'b0;
		#1;
		chk({aspm, cpm}, 4'h6);
		for (int j = 0; j < 2; j++) begin
			acc(1'b1, RA, 4'hF, 32'h48800000, 1'b1, 32'h0);
			pulse_sync(j == 0);
			chk(outs, 9'h0E0);
			acc(1'b0, RA, 4'hF, 32'h0, 1'b1, 32'h84000000);
		end
		$display("load and reset test done");
	endtask : t_load
	task t_retry;
		int unsigned n;
		for (int s = 0; s < 4; s++) begin
			acc(1'b1, RA, 4'h8, {s[1:0], 4'h1, 26'h0}, 1'b1, 32'h0);
			@(posedge clk);
			start <= 1'b1;
			@(posedge clk);
			start <= 1'b0;
			n = 0;
			#1;
			chk(busy, 1'b1);
			while (crs !== 1'b1 && n < 20) begin
				@(posedge clk);
				#1;
				n++;
			end
			chk(n, nt[s]);
			chk({busy, crs}, 2'h1);
			@(posedge clk);
			done <= 1'b1;
			@(posedge clk);
			done <= 1'b0;
			#1;
			chk({busy, crs}, 2'h0);
		end
		$display("retry test done");
	endtask : t_retry
	////////////////////////////////////////////////////////////////////////////////
	task conclude;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		t_fields;
		t_load;
		t_retry;
		conclude;
	end
	// The whole sequence needs about a hundred cycles; a hang is cut well beyond that.
	initial begin
		repeat (3000) @(posedge clk);
		bad_count++;
		conclude;
	end
endmodule : bgcu_general_ctrl_bench
